// [srp_pkg.sv]
// Shared constants for the system reset and power control block.
// Assumes one 100 MHz system clock and a management host on MDIO.
`default_nettype none
package srp_pkg;

	// Management frame layout
	localparam logic [4:0]  DEV_ADDR      = 5'h1E;
	localparam logic [1:0]  OP_ADDR       = 2'h0;
	localparam logic [1:0]  OP_WRITE      = 2'h1;
	localparam logic [1:0]  OP_RD_INC     = 2'h2;
	localparam logic [1:0]  OP_READ       = 2'h3;
	localparam logic [5:0]  PREAMBLE_LEN  = 6'h20;
	localparam logic [5:0]  HDR_LAST      = 6'h0D;
	localparam logic [5:0]  XFER_LAST     = 6'h11;
	localparam logic [5:0]  RD_DATA_LAST  = 6'h10;

	// Register offsets
	localparam logic [15:0] OFS_FLAGS     = 16'h0010;
	localparam logic [15:0] OFS_MASK      = 16'h0020;
	localparam logic [15:0] OFS_SOFT_RST  = 16'h8810;
	localparam logic [15:0] OFS_PD_CTRL   = 16'h8812;
	localparam logic [15:0] OFS_PHY_RST   = 16'h8814;
	localparam logic [15:0] OFS_MAC_RST   = 16'h8815;
	localparam logic [15:0] OFS_STATUS    = 16'h8818;
	localparam logic [15:0] OFS_PMG_CTRL  = 16'h8819;
	localparam logic [15:0] OFS_DIAG_CLK  = 16'h882C;

	// Field positions
	localparam int BIT_SW_IRQ  = 15;
	localparam int BIT_HW_RST  = 12;
	localparam int BIT_CTRL    = 0;
	localparam int BIT_PD_RDY  = 1;
	localparam int BIT_SYS_RDY = 0;

	// Reset values
	localparam logic [15:0] RST_MASK      = 16'h1FFE;
	localparam logic [15:0] RST_FLAGS     = 16'h1000;
	localparam logic [15:0] RST_DIAG      = 16'h0002;
	localparam logic        RST_CTRL_BIT  = 1'h0;

	// Timing
	localparam int CLK_PERIOD_NS  = 10;
	localparam int SOFT_RST_NS    = 1000;
	localparam int STARTUP_NS     = 2000;
	localparam int SUB_RST_NS     = 500;
	localparam int PD_SETTLE_NS   = 200;
	localparam int SOFT_RST_CYC   =
		(SOFT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STARTUP_CYC    =
		(STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SUB_RST_CYC    =
		(SUB_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PD_SETTLE_CYC  =
		(PD_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Serial slave states
	typedef enum logic [1:0] {
		ST_PRE  = 2'b00,
		ST_HDR  = 2'b01,
		ST_XFER = 2'b10
	} srp_mdio_state_t;

endpackage : srp_pkg
`default_nettype wire

// [srp_pulse_seq.sv]
// Timed sequence: busy for LEN cycles after a start, then a done pulse.
// Assumes start is a one-cycle pulse from logic on sys_clk.
`timescale 1ns/100ps
`default_nettype none
module srp_pulse_seq
	import srp_pkg::*;
#(
	parameter int LEN = 1
)(
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic rstn,
	// Sequence control
	input  wire logic start,
	output var  logic busy_r,
	output var  logic done_r
);

	localparam logic [15:0] LAST = 16'(LEN - 1);

	logic [15:0] cnt_r;

	// Starts while busy are ignored, so one sequence never stretches
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			busy_r <= 1'b0;
			done_r <= 1'b0;
			cnt_r  <= 16'h0000;
		end
		else
		begin
			done_r <= 1'b0;
			if (!busy_r)
			begin
				busy_r <= start;
				cnt_r  <= 16'h0000;
			end
			else if (cnt_r == LAST)
			begin
				busy_r <= 1'b0;
				done_r <= 1'b1;
			end
			else
				cnt_r <= cnt_r + 16'h0001;
		end
	end

endmodule : srp_pulse_seq
`default_nettype wire

// [srp_mdio_slave.sv]
// Clause 45 style management serial slave, oversampled on sys_clk.
// Assumes the management clock is far slower than sys_clk.
`timescale 1ns/100ps
`default_nettype none
module srp_mdio_slave
	import srp_pkg::*;
#(
	parameter logic [4:0] PORT_ADDR = 5'h00
)(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	// Management pins
	input  wire logic        mdc,
	input  wire logic        mdio_in,
	output var  logic        mdio_out_r,
	output var  logic        mdio_oe_r,
	// Register access
	output var  logic        rd_req_r,
	output var  logic        wr_req_r,
	output var  logic [15:0] reg_addr_r,
	output var  logic [15:0] wr_data_r,
	input  wire logic [15:0] rd_data
);

	srp_mdio_state_t state_r;
	logic [5:0]  cnt_r;
	logic [15:0] sh_r;
	logic [1:0]  op_r;
	logic        hit_r;
	logic        mdc_s1, mdc_s2, mdc_s3;
	logic        md_s1, md_s2;
	logic        edge_w;
	logic [13:0] hdr_w;

	// Data passes two flops, clock three for its edge; both lines share the same delay
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			{mdc_s1, mdc_s2, mdc_s3} <= 3'h0;
			{md_s1, md_s2}           <= 2'h0;
		end
		else
		begin
			{mdc_s1, mdc_s2, mdc_s3} <= {mdc, mdc_s1, mdc_s2};
			{md_s1, md_s2}           <= {mdio_in, md_s1};
		end
	end

	assign edge_w = mdc_s2 & ~mdc_s3;
	assign hdr_w  = {sh_r[12:0], md_s2};

	// Frame walker: preamble, header, turnaround and data
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_r    <= ST_PRE;
			cnt_r      <= 6'h00;
			sh_r       <= 16'h0000;
			op_r       <= OP_ADDR;
			hit_r      <= 1'b0;
			rd_req_r   <= 1'b0;
			wr_req_r   <= 1'b0;
			reg_addr_r <= 16'h0000;
			wr_data_r  <= 16'h0000;
			mdio_out_r <= 1'b0;
			mdio_oe_r  <= 1'b0;
		end
		else
		begin
			rd_req_r <= 1'b0;
			wr_req_r <= 1'b0;
			if (edge_w)
			begin
				case (state_r)
				ST_PRE:
					if (md_s2)
						cnt_r <= (cnt_r == PREAMBLE_LEN) ? cnt_r
							: cnt_r + 6'h01;
					else if (cnt_r == PREAMBLE_LEN)
					begin
						state_r <= ST_HDR;
						cnt_r   <= 6'h01;
						sh_r    <= 16'h0000;
					end
					else
						cnt_r <= 6'h00;
				ST_HDR:
				begin
					sh_r  <= {sh_r[14:0], md_s2};
					cnt_r <= cnt_r + 6'h01;
					if (cnt_r == HDR_LAST)
					begin
						op_r    <= hdr_w[11:10];
						hit_r   <= (hdr_w[13:12] == 2'h0) &&
							(hdr_w[9:5] == PORT_ADDR) &&
							(hdr_w[4:0] == DEV_ADDR);
						rd_req_r <= (hdr_w[13:12] == 2'h0) &&
							(hdr_w[9:5] == PORT_ADDR) &&
							(hdr_w[4:0] == DEV_ADDR) && hdr_w[11];
						state_r <= ST_XFER;
						cnt_r   <= 6'h00;
					end
				end
				ST_XFER:
				begin
					cnt_r <= cnt_r + 6'h01;
					// Reads drive 0 in the second turnaround bit
					if (hit_r && op_r[1])
					begin
						if (cnt_r == 6'h00)
						begin
							mdio_oe_r  <= 1'b1;
							mdio_out_r <= 1'b0;
							sh_r       <= rd_data;
						end
						else if (cnt_r <= RD_DATA_LAST)
						begin
							mdio_out_r <= sh_r[15];
							sh_r       <= {sh_r[14:0], 1'b0};
						end
					end
					else
						sh_r <= {sh_r[14:0], md_s2};
					if (cnt_r == XFER_LAST)
					begin
						state_r   <= ST_PRE;
						cnt_r     <= 6'h00;
						mdio_oe_r <= 1'b0;
						if (hit_r && op_r == OP_ADDR)
							reg_addr_r <= {sh_r[14:0], md_s2};
						if (hit_r && op_r == OP_WRITE)
						begin
							wr_req_r  <= 1'b1;
							wr_data_r <= {sh_r[14:0], md_s2};
						end
						if (hit_r && op_r == OP_RD_INC)
							reg_addr_r <= reg_addr_r + 16'h0001;
					end
				end
				default:
					state_r <= ST_PRE;
				endcase
			end
		end
	end

endmodule : srp_mdio_slave
`default_nettype wire

// [srp_ctrl.sv]
// System reset, power-down and interrupt control, reached over MDIO.
// Assumes the downstream blocks honour the reset and power levels.
`timescale 1ns/100ps
`default_nettype none
module srp_ctrl
	import srp_pkg::*;
#(
	parameter logic [4:0] PORT_ADDR = 5'h00
)(
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic rstn,
	// Management pins
	input  wire logic mdc,
	input  wire logic mdio_in,
	output var  logic mdio_out,
	output var  logic mdio_oe,
	// Strap
	input  wire logic power_down_strap_pin,
	// Chip controls
	output var  logic chip_reset,
	output var  logic phy_subsystem_reset,
	output var  logic mac_interface_reset,
	output var  logic power_down,
	output var  logic force_boot_oscillator,
	output var  logic diagnostics_clock_enable,
	output var  logic irq_n
);

	localparam int SOFT_MAX = SOFT_RST_CYC + 2;
	localparam int SUB_MAX  = SUB_RST_CYC + 2;
	localparam int PD_MAX   = PD_SETTLE_CYC + 3;
	localparam logic [7:0] PD_LAST = 8'(PD_SETTLE_CYC - 1);

	logic        rd_req, wr_req;
	logic [15:0] reg_addr, wr_data;
	logic [15:0] rd_data_r;
	logic        strap_s1, strap_s2;
	logic        por_r;
	logic [1:0]  init_cnt_r;
	logic        init_load;
	logic        soft_busy, soft_done, soft_start;
	logic        boot_busy, boot_done;
	logic        phy_start, mac_start;
	logic        hw_en_r;
	logic [11:0] mask_low_r;
	logic        flag_sw_r, flag_hw_r;
	logic        pd_bit_r, pd_reached_r;
	logic [7:0]  pd_cnt_r;
	logic        sys_ready_r;
	logic        irq_n_r;
	logic        wr_mask, wr_pd, wr_pmg, wr_diag, rd_flags;

	// Address match used by every write and the clear-on-read
	function automatic logic at(input logic req, input logic [15:0] a,
		input logic [15:0] ofs);
		at = req && (a == ofs);
	endfunction : at

	assign wr_mask    = at(wr_req, reg_addr, OFS_MASK);
	assign wr_pd      = at(wr_req, reg_addr, OFS_PD_CTRL);
	assign wr_pmg     = at(wr_req, reg_addr, OFS_PMG_CTRL);
	assign wr_diag    = at(wr_req, reg_addr, OFS_DIAG_CLK);
	assign rd_flags   = at(rd_req, reg_addr, OFS_FLAGS);
	assign soft_start = at(wr_req, reg_addr, OFS_SOFT_RST) &&
		wr_data[BIT_CTRL] && !soft_busy;
	assign phy_start  = at(wr_req, reg_addr, OFS_PHY_RST) &&
		wr_data[BIT_CTRL];
	assign mac_start  = at(wr_req, reg_addr, OFS_MAC_RST) &&
		wr_data[BIT_CTRL];
	assign init_load  = (init_cnt_r == 2'h2);

	// Serial slave; never reset by soft reset so a frame is not cut
	srp_mdio_slave #(
		.PORT_ADDR (PORT_ADDR)
	) u_mdio (
		.sys_clk    (sys_clk),
		.rstn       (rstn),
		.mdc        (mdc),
		.mdio_in    (mdio_in),
		.mdio_out_r (mdio_out),
		.mdio_oe_r  (mdio_oe),
		.rd_req_r   (rd_req),
		.wr_req_r   (wr_req),
		.reg_addr_r (reg_addr),
		.wr_data_r  (wr_data),
		.rd_data    (rd_data_r)
	);

	// Timed reset sequences
	srp_pulse_seq #(.LEN(SOFT_RST_CYC)) u_soft (
		.sys_clk (sys_clk),
		.rstn    (rstn),
		.start   (soft_start),
		.busy_r  (chip_reset),
		.done_r  (soft_done)
	);
	srp_pulse_seq #(.LEN(STARTUP_CYC)) u_boot (
		.sys_clk (sys_clk),
		.rstn    (rstn),
		.start   (por_r | soft_done),
		.busy_r  (boot_busy),
		.done_r  (boot_done)
	);
	srp_pulse_seq #(.LEN(SUB_RST_CYC)) u_phy (
		.sys_clk (sys_clk),
		.rstn    (rstn),
		.start   (phy_start),
		.busy_r  (phy_subsystem_reset),
		.done_r  ()
	);
	srp_pulse_seq #(.LEN(SUB_RST_CYC)) u_mac (
		.sys_clk (sys_clk),
		.rstn    (rstn),
		.start   (mac_start),
		.busy_r  (mac_interface_reset),
		.done_r  ()
	);

	assign soft_busy = chip_reset;

	// Strap synchroniser and power-on start pulse
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			strap_s1 <= 1'b0;
			strap_s2 <= 1'b0;
			por_r    <= 1'b1;
		end
		else
		begin
			strap_s1 <= power_down_strap_pin;
			strap_s2 <= strap_s1;
			por_r    <= 1'b0;
		end
	end

	// Strap is taken once the synchroniser holds a settled value
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			init_cnt_r <= 2'h0;
		else if (soft_done)
			init_cnt_r <= 2'h0;
		else if (init_cnt_r != 2'h3)
			init_cnt_r <= init_cnt_r + 2'h1;
	end

	// Power-down bit; soft reset reloads it from the strap
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			pd_bit_r <= RST_CTRL_BIT;
		else if (init_load)
			pd_bit_r <= strap_s2;
		else if (wr_pd)
			pd_bit_r <= wr_data[BIT_CTRL];
	end

	// Reached flag waits for the shutdown to settle
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pd_cnt_r     <= 8'h00;
			pd_reached_r <= 1'b0;
		end
		else if (!pd_bit_r)
		begin
			pd_cnt_r     <= 8'h00;
			pd_reached_r <= 1'b0;
		end
		else if (pd_cnt_r == PD_LAST)
			pd_reached_r <= 1'b1;
		else
			pd_cnt_r <= pd_cnt_r + 8'h01;
	end

	// Mask register and plain controls, all reinitialized by soft reset
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			hw_en_r    <= RST_MASK[BIT_HW_RST];
			mask_low_r <= RST_MASK[11:0];
			force_boot_oscillator    <= RST_CTRL_BIT;
			diagnostics_clock_enable <= RST_DIAG[BIT_CTRL];
		end
		else if (soft_done)
		begin
			hw_en_r    <= RST_MASK[BIT_HW_RST];
			mask_low_r <= RST_MASK[11:0];
			force_boot_oscillator    <= RST_CTRL_BIT;
			diagnostics_clock_enable <= RST_DIAG[BIT_CTRL];
		end
		else
		begin
			if (wr_mask)
			begin
				hw_en_r    <= wr_data[BIT_HW_RST];
				mask_low_r <= wr_data[11:0];
			end
			if (wr_pmg)
				force_boot_oscillator <= wr_data[BIT_CTRL];
			if (wr_diag)
				diagnostics_clock_enable <= wr_data[BIT_CTRL];
		end
	end

	// Event flags; a set in the clearing cycle wins over the read clear
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			flag_sw_r <= RST_FLAGS[BIT_SW_IRQ];
			flag_hw_r <= RST_FLAGS[BIT_HW_RST];
		end
		else
		begin
			if (wr_mask && wr_data[BIT_SW_IRQ])
				flag_sw_r <= 1'b1;
			else if (rd_flags)
				flag_sw_r <= 1'b0;
			if (rd_flags)
				flag_hw_r <= 1'b0;
		end
	end

	// Ready drops at a soft reset and returns after start-up
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			sys_ready_r <= 1'b0;
		else if (soft_start)
			sys_ready_r <= 1'b0;
		else if (boot_done)
			sys_ready_r <= 1'b1;
	end

	// Software requests always reach the pin; reset event needs its enable
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			irq_n_r <= 1'b1;
		else
			irq_n_r <= !(flag_sw_r || (flag_hw_r && hw_en_r));
	end

	assign irq_n      = irq_n_r;
	assign power_down = pd_bit_r;

	// Read data is latched at the header so clear-on-read cannot race it
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			rd_data_r <= 16'h0000;
		else if (rd_req)
		begin
			case (reg_addr)
			OFS_FLAGS:    rd_data_r <= {flag_sw_r, 2'h0, flag_hw_r, 12'h000};
			OFS_MASK:     rd_data_r <= {3'h0, hw_en_r, mask_low_r};
			OFS_SOFT_RST: rd_data_r <= {15'h0000, soft_busy};
			OFS_PD_CTRL:  rd_data_r <= {15'h0000, pd_bit_r};
			OFS_PHY_RST:  rd_data_r <= {15'h0000, phy_subsystem_reset};
			OFS_MAC_RST:  rd_data_r <= {15'h0000, mac_interface_reset};
			OFS_STATUS:   rd_data_r <= {14'h0000, pd_reached_r, sys_ready_r};
			OFS_PMG_CTRL: rd_data_r <= {15'h0000, force_boot_oscillator};
			OFS_DIAG_CLK: rd_data_r <= RST_DIAG & 16'hFFFE |
				{15'h0000, diagnostics_clock_enable};
			default:      rd_data_r <= 16'h0000;
			endcase
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	sequence sw_req_s;
		wr_mask && wr_data[BIT_SW_IRQ];
	endsequence
	// Busy holds, then drops within the bounded run length
	sequence sub_run_s(logic busy);
		busy ##[1:SUB_MAX] !busy;
	endsequence

	irq_follow_a: assert property (flag_hw_r && hw_en_r |=> !irq_n)
		else $error("reset event with enable did not drive irq");
	sw_irq_raise_a: assert property (sw_req_s |=> flag_sw_r ##1 !irq_n)
		else $error("software request did not raise interrupt");
	sw_read_zero_a: assert property (at(rd_req, reg_addr, OFS_MASK)
		|=> !rd_data_r[BIT_SW_IRQ])
		else $error("software request bit read as one");
	hw_en_reinit_a: assert property (soft_done |=> hw_en_r)
		else $error("reset interrupt enable not one after reset");
	soft_seq_a: assert property (soft_start |=> chip_reset ##[1:SOFT_MAX]
		(!chip_reset && hw_en_r && mask_low_r == RST_MASK[11:0]))
		else $error("soft reset did not finish and reinitialize");
	pd_out_a: assert property (wr_pd && !init_load
		|=> power_down == $past(wr_data[BIT_CTRL]))
		else $error("power-down write not applied");
	strap_load_a: assert property (init_load
		|=> pd_bit_r == $past(strap_s2))
		else $error("power-down bit did not follow strap");
	phy_seq_a: assert property (phy_start && !phy_subsystem_reset
		|=> sub_run_s(phy_subsystem_reset))
		else $error("PHY subsystem reset did not self-clear");
	mac_seq_a: assert property (mac_start && !mac_interface_reset
		|=> sub_run_s(mac_interface_reset))
		else $error("MAC interface reset did not self-clear");
	pd_reach_a: assert property ($rose(pd_bit_r) |-> !pd_reached_r
		##[1:PD_MAX] pd_reached_r)
		else $error("power-down status wrong");
	pd_drop_a: assert property (!pd_bit_r |=> !pd_reached_r)
		else $error("power-down status set while running");
	ready_drop_a: assert property (soft_start |=> !sys_ready_r)
		else $error("ready stayed set during soft reset");
	osc_write_a: assert property (wr_pmg && !soft_done
		|=> force_boot_oscillator == $past(wr_data[BIT_CTRL]))
		else $error("oscillator force not written");
	diag_read_a: assert property (at(rd_req, reg_addr, OFS_DIAG_CLK)
		|=> rd_data_r[15:1] == RST_DIAG[15:1])
		else $error("diagnostics clock register read wrong");
	flag_clear_a: assert property (rd_flags && !wr_mask
		|=> !flag_sw_r && !flag_hw_r)
		else $error("flags not cleared by read");

endmodule : srp_ctrl
`default_nettype wire

// [srp_host_model.sv]
// Management host model: clocks clause 45 frames into the device.
// Assumes sys_clk from the bench; mdc and host data change on its falling edge only.
`timescale 1ns/100ps
`default_nettype none
module srp_host_model
	import srp_pkg::*;
#(
	parameter logic [4:0] PORT = 5'h00
)(
	// Clock
	input  wire logic sys_clk,
	// Management pins
	output var  logic mdc,
	output var  logic mdio_in,
	input  wire logic mdio_out,
	input  wire logic mdio_oe
);
	logic host_d;
	logic host_oe;

	// Line level; the pull-up wins when nobody drives
	always_comb
		mdio_in = mdio_oe ? mdio_out : (host_oe ? host_d : 1'h1);

	// Idle: clock low, line released
	initial
	begin
		mdc     = 1'h0;
		host_d  = 1'h1;
		host_oe = 1'h0;
	end

	// Preamble of 32 ones, then 32 bit times; read data sampled late low
	task automatic frame(input logic [1:0] op, input logic [15:0] wd,
		output logic [15:0] rd);
		logic [63:0] bits;
		bits = {32'hFFFFFFFF, 2'h0, op, PORT, DEV_ADDR, 2'h2, wd};
		rd = 16'h0000;
		for (int i = 0; i < 64; i++)
		begin
			@(negedge sys_clk);
			mdc     = 1'h0;
			host_d  = bits[63 - i];
			host_oe = !(op[1] && i >= 46); // Read: release at turnaround
			repeat (5) @(negedge sys_clk);
			if (i >= 48)
				rd[63 - i] = mdio_in;
			mdc = 1'h1;
			repeat (4) @(negedge sys_clk);
		end
		@(negedge sys_clk);
		mdc     = 1'h0;
		host_oe = 1'h0;
		repeat (8) @(negedge sys_clk);
	endtask : frame

	// Address frame, then data frame
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		logic [15:0] x;
		frame(OP_ADDR, a, x);
		frame(OP_WRITE, d, x);
	endtask : wr

	task automatic rd(input logic [15:0] a, output logic [15:0] d);
		logic [15:0] x;
		frame(OP_ADDR, a, x);
		frame(OP_READ, 16'h0000, d);
	endtask : rd

	// Bounded poll of the ready bit before normal use
	task automatic poll_ready(output logic ok);
		logic [15:0] d;
		ok = 1'h0;
		for (int n = 0; n < 8 && !ok; n++)
		begin
			rd(OFS_STATUS, d);
			ok = (d[BIT_SYS_RDY] === 1'h1);
		end
	endtask : poll_ready
endmodule : srp_host_model
`default_nettype wire

// [srp_ctrl_tb.sv]
// Self-checking bench for the reset and power control block.
// Assumes the host model above and the package constants.
`timescale 1ns/100ps
`default_nettype none
module srp_ctrl_tb
	import srp_pkg::*;
;
	localparam logic [4:0]  PA = 5'h03;
	// Reset values, last entry unmapped
	localparam logic [15:0] TA [9] = '{OFS_MASK, OFS_SOFT_RST, OFS_PD_CTRL,
		OFS_PHY_RST, OFS_MAC_RST, OFS_STATUS, OFS_PMG_CTRL, OFS_DIAG_CLK,
		16'h8811};
	localparam logic [15:0] TV [9] = '{16'h1FFE, 16'h0000, 16'h0000,
		16'h0000, 16'h0000, 16'h0001, 16'h0000, 16'h0002, 16'h0000};

	logic sys_clk;
	logic rstn;
	logic strap;
	logic mdc;
	logic mdio_in;
	logic mdio_out;
	logic mdio_oe;
	logic chip_reset;
	logic phy_rst;
	logic mac_rst;
	logic power_down;
	logic force_osc;
	logic diag_en;
	logic irq_n;
	logic ok;
	logic [15:0] rdv;
	int   failures;
	int   check_count;
	int   rst_cnt;
	int   phy_cnt;
	int   mac_cnt;

	srp_ctrl #(.PORT_ADDR(PA)) srp_ctrl_i (
		.sys_clk                  (sys_clk),
		.rstn                     (rstn),
		.mdc                      (mdc),
		.mdio_in                  (mdio_in),
		.mdio_out                 (mdio_out),
		.mdio_oe                  (mdio_oe),
		.power_down_strap_pin     (strap),
		.chip_reset               (chip_reset),
		.phy_subsystem_reset      (phy_rst),
		.mac_interface_reset      (mac_rst),
		.power_down               (power_down),
		.force_boot_oscillator    (force_osc),
		.diagnostics_clock_enable (diag_en),
		.irq_n                    (irq_n)
	);

	srp_host_model #(.PORT(PA)) srp_host_model_i (
		.sys_clk  (sys_clk),
		.mdc      (mdc),
		.mdio_in  (mdio_in),
		.mdio_out (mdio_out),
		.mdio_oe  (mdio_oe)
	);

	// Clock
	initial
	begin
		sys_clk = 1'h0;
		forever #(CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;
	end

	// Pulse lengths, zeroed once at the start; each reset is requested only once
	always @(posedge sys_clk)
	begin
		rst_cnt <= rst_cnt + int'(chip_reset);
		phy_cnt <= phy_cnt + int'(phy_rst);
		mac_cnt <= mac_cnt + int'(mac_rst);
	end

	task automatic cmp_reg(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp)
		begin
			failures++;
			$display("Error %0t: value %h expected %h", $time, got, exp);
		end
	endtask : cmp_reg

	task automatic cmp_pin(input logic got, input logic exp);
		check_count++;
		if (got !== exp)
		begin
			failures++;
			$display("Error %0t: pin %b expected %b", $time, got, exp);
		end
	endtask : cmp_pin

	task automatic chk(input logic [15:0] a, input logic [15:0] exp);
		logic [15:0] d;
		srp_host_model_i.rd(a, d);
		cmp_reg(d, exp);
	endtask : chk

	task automatic give_verdict;
		$display("Checks %0d, errors %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : give_verdict

	// Watchdog: the whole sequence needs about 53000 cycles
	initial
	begin
		repeat (95000) @(posedge sys_clk);
		failures++;
		$display("Error %0t: watchdog expired", $time);
		give_verdict;
	end

	// Main sequence
	initial
	begin
		failures = 0;
		check_count = 0;
		rst_cnt = 0;
		phy_cnt = 0;
		mac_cnt = 0;
		rstn = 1'h0;
		strap = 1'h0;
		repeat (10) @(negedge sys_clk);
		rstn = 1'h1;
		repeat (3) @(negedge sys_clk);
		cmp_pin(irq_n, 1'h0);
		srp_host_model_i.poll_ready(ok);
		cmp_pin(ok, 1'h1);
		for (int i = 0; i < 9; i++)
			chk(TA[i], TV[i]);
		chk(OFS_FLAGS, RST_FLAGS);
		chk(OFS_FLAGS, 16'h0000);
		cmp_pin(irq_n, 1'h1);
		// Test interrupt; request bit and reserved bits read zero
		srp_host_model_i.wr(OFS_MASK, 16'hFFFF);
		cmp_pin(irq_n, 1'h0);
		chk(OFS_MASK, 16'h1FFF);
		chk(OFS_FLAGS, 16'h8000);
		cmp_pin(irq_n, 1'h1);
		srp_host_model_i.wr(OFS_PMG_CTRL, 16'hFFFF);
		cmp_pin(force_osc, 1'h1);
		chk(OFS_PMG_CTRL, 16'h0001);
		// Post-increment read: the plain read after it lands one higher
		srp_host_model_i.frame(OP_ADDR, OFS_PMG_CTRL, rdv);
		srp_host_model_i.frame(OP_RD_INC, 16'h0000, rdv);
		cmp_reg(rdv, 16'h0001);
		srp_host_model_i.frame(OP_READ, 16'h0000, rdv);
		cmp_reg(rdv, 16'h0000);
		srp_host_model_i.wr(OFS_DIAG_CLK, 16'hFFFF);
		cmp_pin(diag_en, 1'h1);
		chk(OFS_DIAG_CLK, 16'h0003);
		// Power-down keeps registers reachable
		srp_host_model_i.wr(OFS_PD_CTRL, 16'h0001);
		cmp_pin(power_down, 1'h1);
		chk(OFS_STATUS, 16'h0003);
		chk(OFS_PMG_CTRL, 16'h0001);
		srp_host_model_i.wr(OFS_PD_CTRL, 16'h0000);
		cmp_pin(power_down, 1'h0);
		chk(OFS_STATUS, 16'h0001);
		// Managed subsystem resets run their full length, then clear
		srp_host_model_i.wr(OFS_PHY_RST, 16'hFFFF);
		repeat (SUB_RST_CYC + 4) @(negedge sys_clk);
		cmp_reg(16'(phy_cnt), 16'(SUB_RST_CYC));
		chk(OFS_PHY_RST, 16'h0000);
		srp_host_model_i.wr(OFS_MAC_RST, 16'hFFFF);
		repeat (SUB_RST_CYC + 4) @(negedge sys_clk);
		cmp_reg(16'(mac_cnt), 16'(SUB_RST_CYC));
		chk(OFS_MAC_RST, 16'h0000);
		cmp_reg(16'(rst_cnt), 16'h0000);
		// Soft reset restores the controls changed above
		srp_host_model_i.wr(OFS_MASK, 16'h0000);
		chk(OFS_MASK, 16'h0000);
		srp_host_model_i.wr(OFS_SOFT_RST, 16'h0001);
		repeat (SOFT_RST_CYC + 4) @(negedge sys_clk);
		cmp_reg(16'(rst_cnt), 16'(SOFT_RST_CYC));
		cmp_pin(force_osc, 1'h0);
		chk(OFS_MASK, RST_MASK);
		chk(OFS_PMG_CTRL, 16'h0000);
		chk(OFS_DIAG_CLK, RST_DIAG);
		chk(OFS_SOFT_RST, 16'h0000);
		srp_host_model_i.poll_ready(ok);
		cmp_pin(ok, 1'h1);
		// Hardware reset with the strap high; enable cleared beforehand
		srp_host_model_i.wr(OFS_MASK, 16'h0000);
		strap = 1'h1;
		rstn = 1'h0;
		repeat (10) @(negedge sys_clk);
		rstn = 1'h1;
		repeat (5) @(negedge sys_clk);
		cmp_pin(power_down, 1'h1);
		cmp_pin(irq_n, 1'h0);
		chk(OFS_PD_CTRL, 16'h0001);
		chk(OFS_MASK, RST_MASK);
		give_verdict;
	end
endmodule : srp_ctrl_tb
`default_nettype wire
